// ---- config_word_pkg.sv ----
// shared constants, types and layouts for the configuration word decoder
`default_nettype none
package config_word_pkg;

   // ************************************************************
   // clock and timing
   // ************************************************************
   localparam int          CLK_MHZ          = 40;
   localparam int          PLL_TIMEOUT_NS   = 1000;
   localparam int          PLL_TIMEOUT_CYC  = (PLL_TIMEOUT_NS * CLK_MHZ + 999) / 1000;
   localparam logic [7:0]  PLL_TIMEOUT_LOAD = 8'(PLL_TIMEOUT_CYC);

   // ************************************************************
   // word indices and register byte offsets
   // ************************************************************
   localparam int          NUM_WORDS   = 6;
   localparam int          W_SECURITY  = 0;
   localparam int          W_BOOTLIM   = 1;
   localparam int          W_SIGNATURE = 2;
   localparam int          W_OSCSEL    = 3;
   localparam int          W_OSCCFG    = 4;
   localparam int          W_WATCHDOG  = 5;
   localparam logic [7:0]  OFF_CODE_SECURITY   = 8'h00;
   localparam logic [7:0]  OFF_BOOT_LIMIT      = 8'h04;
   localparam logic [7:0]  OFF_SIGNATURE       = 8'h08;
   localparam logic [7:0]  OFF_OSC_SELECT      = 8'h0c;
   localparam logic [7:0]  OFF_OSC_CONFIG      = 8'h10;
   localparam logic [7:0]  OFF_WATCHDOG_CFG    = 8'h14;
   localparam logic [7:0]  OFF_WATCHDOG_CTRL   = 8'h18;
   localparam logic [7:0]  OFF_STATUS          = 8'h1c;
   localparam logic [2:0]  IDX_WATCHDOG_CTRL   = 3'h6;
   localparam logic [2:0]  IDX_STATUS          = 3'h7;

   // ************************************************************
   // implemented-bit masks; all other bits read as one
   // ************************************************************
   localparam logic [23:0] MASK_SECURITY  = 24'h008fef;
   localparam logic [23:0] MASK_BOOTLIM   = 24'h001fff;
   localparam logic [23:0] MASK_SIGNATURE = 24'h008000;
   localparam logic [23:0] MASK_OSCSEL    = 24'h000087;
   localparam logic [23:0] MASK_OSCCFG    = 24'h001dc7;
   localparam logic [23:0] MASK_WATCHDOG  = 24'h00ffff;
   localparam logic [23:0] ALL_ONES       = 24'hffffff;

   // ************************************************************
   // field positions
   // ************************************************************
   localparam int SEC_ALT_VEC   = 15;
   localparam int SEC_CFG_LVL   = 9;
   localparam int SEC_CFG_WP    = 8;
   localparam int SEC_GEN_LVL   = 6;
   localparam int SEC_GEN_WP    = 5;
   localparam int SEC_BOOT_CTL  = 3;
   localparam int SEC_BOOT_LVL  = 1;
   localparam int SEC_BOOT_WP   = 0;
   localparam int SEL_TWO_SPEED = 7;
   localparam int SEL_OSC       = 0;
   localparam int OSC_BOOST     = 12;
   localparam int OSC_GAIN      = 10;
   localparam int OSC_LOCK_GATE = 8;
   localparam int OSC_SWITCH    = 6;
   localparam int OSC_OUT_FUNC  = 2;
   localparam int OSC_PRIMARY   = 0;
   localparam int WD_HW_EN      = 15;
   localparam int WD_SLEEP_PER  = 10;
   localparam int WD_WINDOW     = 8;
   localparam int WD_WIN_DIS    = 7;
   localparam int WD_CLK_SEL    = 5;
   localparam int WD_RUN_PER    = 0;
   localparam int CTRL_WD_ON    = 15;
   localparam logic [31:0] CTRL_RESET = 32'h00000000;

   // ************************************************************
   // types
   // ************************************************************
   typedef enum logic [1:0] {
      PROT_NONE = 2'h0, PROT_STANDARD = 2'h1, PROT_ENHANCED = 2'h2, PROT_HIGH = 2'h3
   } protect_level_e;
   typedef enum logic [1:0] {
      PRI_EXT_CLOCK = 2'h0, PRI_STD_CRYSTAL = 2'h1, PRI_HS_CRYSTAL = 2'h2, PRI_DISABLED = 2'h3
   } primary_mode_e;
   typedef enum logic [2:0] {
      WCLK_LOW_POWER_RC = 3'h0, WCLK_FAST_RC = 3'h1, WCLK_PERIPHERAL = 3'h2,
      WCLK_INTERNAL_OSC = 3'h3, WCLK_RESERVED = 3'h4
   } wd_clock_e;

   typedef struct packed {
      logic           alternate_vector_table;
      protect_level_e cfg_segment_protect_level;
      logic           cfg_segment_protected;
      protect_level_e general_segment_protect_level;
      logic           general_segment_protected;
      logic           boot_segment_present;
      protect_level_e boot_segment_protect_level;
      logic           boot_segment_protected;
      logic [12:0]    first_general_page;
   } security_s;

   typedef struct packed {
      logic           two_speed_startup_enable;
      logic [2:0]     initial_osc_select;
      logic           initial_osc_reserved;
      logic           crystal_kickstart_boost;
      logic [1:0]     crystal_drive_gain;
      logic           pll_clock_out_enable;
      logic           clock_switch_enable;
      logic           fail_safe_monitor_enable;
      logic           osc_output_pin_is_clock;
      primary_mode_e  primary_osc_mode;
   } clocking_s;

   typedef struct packed {
      logic           watchdog_on;
      logic [5:0]     sleep_divider_exp;
      logic [5:0]     run_divider_exp;
      logic [2:0]     window_eighths;
      logic           window_mode;
      wd_clock_e      clock_source;
   } watchdog_s;

   typedef struct packed {
      logic           in_sleep;
      logic           sysclk_internal;
      logic           pll_lock;
      logic           pll_enabled;
      logic           pll_request;
   } live_s;

endpackage : config_word_pkg

`default_nettype wire

// ---- config_word_decoder.sv ----
// configuration word latch, decoder and APB read-back
//
// What this block does
// (R1) Unimplemented bits of every 24-bit word, upper byte included, read as one.
// (R2) Alternate vector table disabled when security bit 15 is one, else enabled.
// (R3) Config segment level: 111 none, 110 standard, 10x enhanced, 0xx high.
// (R4) Write-protect bits at 8, 5, 0 protect their region when zero.
// (R5) General segment level: 11 none, 10 standard, 0x high.
// (R6) Boot control bit 3 one means no boot segment; zero uses the limit.
// (R7) Boot segment level at bits 2-1: 11 none, 10 standard, 0x high.
// (R8) Boot limit holds the inverted first general page address.
// (R9) Programmer keeps signature bit 15 at zero.
// (R10) Oscillator select bit 7 enables two-speed start-up.
// (R11) Initial oscillator code picks one of seven sources; 100 is reserved.
// (R12) Crystal drive code selects gain level 3 down to 0.
// (R13) Lock-gate bit one lets lost PLL lock disable the PLL output.
// (R14) Requesting the PLL while it is off starts a time-out period.
// (R15) Switch mode: 1x both off, 01 switching only, 00 both on.
// (R16) Outside crystal modes, bit 2 makes the output pin a clock output.
// (R17) Primary mode: 11 disabled, 10 HS crystal, 01 crystal, 00 external.
// (R18) Watchdog hardware enable forces it on, else the software on bit.
// (R19) Each period code divides the watchdog clock by two to code plus one.
// (R20) Window codes 11, 10, 01, 00 give 25, 37.5, 50, 75 percent.
// (R21) Window-disable bit zero selects window mode, one non-window mode.
// (R22) Watchdog clock: 11 low-power RC; 10 and 01 conditional; 00 reserved.
// (R23) Words are latched once after reset and then held as static settings.
//
// The APB slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module config_word_decoder (
   // clock and reset
   input  wire logic                          clk,
   input  wire logic                          rst_n,
   // nonvolatile words as presented by the flash during reset
   input  wire logic [5:0][23:0]              nvm_words,
   // live status from clock and power logic
   input  wire config_word_pkg::live_s        live,
   // apb slave
   input  wire logic                          psel,
   input  wire logic                          penable,
   input  wire logic                          pwrite,
   input  wire logic [7:0]                    paddr,
   input  wire logic [31:0]                   pwdata,
   output var  logic [31:0]                   prdata,
   output var  logic                          pready,
   output var  logic                          pslverr,
   // decoded settings
   output var  config_word_pkg::security_s    security,
   output var  config_word_pkg::clocking_s    clock_cfg,
   output var  config_word_pkg::watchdog_s    watchdog,
   output var  logic                          pll_timeout_busy,
   output var  logic                          settings_valid
);

   // ************************************************************
   // loader state
   // ************************************************************
   typedef enum logic [1:0] {
      ST_LOAD = 2'b01,
      ST_RUN  = 2'b10
   } load_state_e;

   load_state_e        state_q;
   load_state_e        state_d;
   logic [5:0][23:0]   word_q;
   logic [5:0][23:0]   word_d;
   logic [31:0]        ctrl_q;
   logic [31:0]        ctrl_d;
   logic [7:0]         tmo_q;
   logic [7:0]         tmo_d;
   logic               req_q;
   logic               req_d;

   localparam logic [5:0][23:0] IMPL_MASK = {
      config_word_pkg::MASK_WATCHDOG, config_word_pkg::MASK_OSCCFG,
      config_word_pkg::MASK_OSCSEL,   config_word_pkg::MASK_SIGNATURE,
      config_word_pkg::MASK_BOOTLIM,  config_word_pkg::MASK_SECURITY };

   // (R23) single capture
   assign state_d = ST_RUN;

   // per-word capture; only happens in the load state after release
   for (genvar w = 0; w < config_word_pkg::NUM_WORDS; w++) begin : g_word
      // (R1) force unimplemented ones
      assign word_d[w] = (state_q == ST_LOAD) ? (nvm_words[w] | ~IMPL_MASK[w]) : word_q[w];
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ST_LOAD;
         word_q  <= {config_word_pkg::NUM_WORDS{config_word_pkg::ALL_ONES}};
      end else begin
         state_q <= state_d;
         word_q  <= word_d;
      end
   end

   // ************************************************************
   // field extraction
   // ************************************************************
   wire logic [23:0] sec_w = word_q[config_word_pkg::W_SECURITY];
   wire logic [23:0] lim_w = word_q[config_word_pkg::W_BOOTLIM];
   wire logic [23:0] sel_w = word_q[config_word_pkg::W_OSCSEL];
   wire logic [23:0] osc_w = word_q[config_word_pkg::W_OSCCFG];
   wire logic [23:0] wdt_w = word_q[config_word_pkg::W_WATCHDOG];

   wire logic [2:0] cfg_lvl_code  = sec_w[config_word_pkg::SEC_CFG_LVL +: 3];
   wire logic [1:0] gen_lvl_code  = sec_w[config_word_pkg::SEC_GEN_LVL +: 2];
   wire logic [1:0] boot_lvl_code = sec_w[config_word_pkg::SEC_BOOT_LVL +: 2];
   wire logic [1:0] switch_code   = osc_w[config_word_pkg::OSC_SWITCH +: 2];
   wire logic [1:0] primary_code  = osc_w[config_word_pkg::OSC_PRIMARY +: 2];
   wire logic [1:0] wclk_code     = wdt_w[config_word_pkg::WD_CLK_SEL +: 2];
   wire logic [1:0] window_code   = wdt_w[config_word_pkg::WD_WINDOW +: 2];
   wire logic [4:0] sleep_code    = wdt_w[config_word_pkg::WD_SLEEP_PER +: 5];
   wire logic [4:0] run_code      = wdt_w[config_word_pkg::WD_RUN_PER +: 5];
   wire logic [2:0] osc_code      = sel_w[config_word_pkg::SEL_OSC +: 3];
   wire logic       win_disable   = wdt_w[config_word_pkg::WD_WIN_DIS];

   // shared two-bit level decode used by general and boot segments
   function automatic config_word_pkg::protect_level_e level2(input logic [1:0] code);
      if (code == 2'h3) begin
         return config_word_pkg::PROT_NONE;
      end else if (code == 2'h2) begin
         return config_word_pkg::PROT_STANDARD;
      end
      return config_word_pkg::PROT_HIGH;
   endfunction : level2

   // ************************************************************
   // security decode
   // ************************************************************
   config_word_pkg::security_s sec_d;
   config_word_pkg::protect_level_e cfg_level;

   // (R3) three-bit level
   assign cfg_level = (cfg_lvl_code == 3'h7) ? config_word_pkg::PROT_NONE :
                      (cfg_lvl_code == 3'h6) ? config_word_pkg::PROT_STANDARD :
                      cfg_lvl_code[2]        ? config_word_pkg::PROT_ENHANCED :
                                               config_word_pkg::PROT_HIGH;

   always_comb begin
      // (R2) vector table enable
      sec_d.alternate_vector_table        = ~sec_w[config_word_pkg::SEC_ALT_VEC];
      sec_d.cfg_segment_protect_level     = cfg_level;
      // (R4) write protect when zero
      sec_d.cfg_segment_protected         = ~sec_w[config_word_pkg::SEC_CFG_WP];
      sec_d.general_segment_protected     = ~sec_w[config_word_pkg::SEC_GEN_WP];
      sec_d.boot_segment_protected        = ~sec_w[config_word_pkg::SEC_BOOT_WP];
      // (R5) general level
      sec_d.general_segment_protect_level = level2(gen_lvl_code);
      // (R7) boot level
      sec_d.boot_segment_protect_level    = level2(boot_lvl_code);
      // (R6) boot segment exists only when control is zero
      sec_d.boot_segment_present          = ~sec_w[config_word_pkg::SEC_BOOT_CTL];
      // (R8) stored inverted so extra zeros only grow the boot segment
      sec_d.first_general_page            = ~lim_w[12:0];
   end

   // ************************************************************
   // oscillator decode
   // ************************************************************
   config_word_pkg::clocking_s clk_d;
   wire logic pll_lost = osc_w[config_word_pkg::OSC_LOCK_GATE] & ~live.pll_lock;
   wire logic crystal_mode = (primary_code == 2'h1) | (primary_code == 2'h2);

   always_comb begin
      // (R10) two-speed start-up
      clk_d.two_speed_startup_enable = sel_w[config_word_pkg::SEL_TWO_SPEED];
      // (R11) source code passed on, reserved code flagged
      clk_d.initial_osc_select       = osc_code;
      clk_d.initial_osc_reserved     = (osc_code == 3'h4);
      clk_d.crystal_kickstart_boost  = osc_w[config_word_pkg::OSC_BOOST];
      // (R12) gain level equals code
      clk_d.crystal_drive_gain       = osc_w[config_word_pkg::OSC_GAIN +: 2];
      // (R13) lost lock gates the output only when enabled
      clk_d.pll_clock_out_enable     = ~pll_lost;
      // (R15) switching and monitor
      clk_d.clock_switch_enable      = ~switch_code[1];
      clk_d.fail_safe_monitor_enable = (switch_code == 2'h0);
      // (R16) crystal modes own the pin regardless of the bit
      clk_d.osc_output_pin_is_clock  = ~crystal_mode & osc_w[config_word_pkg::OSC_OUT_FUNC];
      // (R17) primary mode
      clk_d.primary_osc_mode         = config_word_pkg::primary_mode_e'(primary_code);
   end

   // ************************************************************
   // watchdog decode
   // ************************************************************
   config_word_pkg::watchdog_s wd_d;
   config_word_pkg::wd_clock_e wclk_sel;
   wire logic fast_clock_ok = ~live.sysclk_internal & ~live.in_sleep;

   // (R22) conditional sources fall back to the internal oscillator
   assign wclk_sel = (wclk_code == 2'h3) ? config_word_pkg::WCLK_LOW_POWER_RC :
                     (wclk_code == 2'h2) ? ((fast_clock_ok & ~win_disable) ?
                                            config_word_pkg::WCLK_FAST_RC :
                                            config_word_pkg::WCLK_INTERNAL_OSC) :
                     (wclk_code == 2'h1) ? (fast_clock_ok ? config_word_pkg::WCLK_PERIPHERAL :
                                            config_word_pkg::WCLK_INTERNAL_OSC) :
                                           config_word_pkg::WCLK_RESERVED;

   always_comb begin
      // (R18) hardware enable overrides software
      wd_d.watchdog_on       = wdt_w[config_word_pkg::WD_HW_EN] | ctrl_q[config_word_pkg::CTRL_WD_ON];
      // (R19) exponent is code plus one
      wd_d.sleep_divider_exp = {1'b0, sleep_code} + 6'h01;
      wd_d.run_divider_exp   = {1'b0, run_code} + 6'h01;
      // (R20) window in eighths of the period
      wd_d.window_eighths    = (window_code == 2'h3) ? 3'h2 :
                               (window_code == 2'h2) ? 3'h3 :
                               (window_code == 2'h1) ? 3'h4 : 3'h6;
      // (R21) window mode when disable bit is zero
      wd_d.window_mode       = ~win_disable;
      wd_d.clock_source      = wclk_sel;
   end

   // settings are only trusted once the words are in
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         security       <= '0;
         clock_cfg      <= '0;
         watchdog       <= '0;
         settings_valid <= 1'b0;
      end else begin
         security       <= sec_d;
         clock_cfg      <= clk_d;
         watchdog       <= wd_d;
         settings_valid <= (state_q == ST_RUN);
      end
   end

   // ************************************************************
   // pll request time-out
   // ************************************************************
   wire logic tmo_start = live.pll_request & ~req_q & ~live.pll_enabled;

   assign req_d = live.pll_request;
   // (R14) a fresh request restarts the full period
   assign tmo_d = tmo_start ? config_word_pkg::PLL_TIMEOUT_LOAD :
                  (tmo_q != 8'h00) ? tmo_q - 8'h01 : 8'h00;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tmo_q            <= 8'h00;
         req_q            <= 1'b0;
         pll_timeout_busy <= 1'b0;
      end else begin
         tmo_q            <= tmo_d;
         req_q            <= req_d;
         pll_timeout_busy <= (tmo_d != 8'h00);
      end
   end

   // ************************************************************
   // apb slave, zero wait states
   // ************************************************************
   wire logic        setup     = psel & ~penable;
   wire logic        in_range  = (paddr[7:5] == 3'h0) & (paddr[1:0] == 2'h0);
   wire logic [2:0]  idx       = paddr[4:2];
   wire logic        is_word   = in_range & (idx < 3'(config_word_pkg::NUM_WORDS));
   wire logic        is_ctrl   = in_range & (idx == config_word_pkg::IDX_WATCHDOG_CTRL);
   wire logic        is_stat   = in_range & (idx == config_word_pkg::IDX_STATUS);
   // words and status are read-only; writes to them answer with an error
   wire logic        bad       = ~in_range | (pwrite & ~is_ctrl);
   wire logic        ctrl_wr   = psel & penable & pready & pwrite & ~pslverr;
   wire logic [31:0] stat_word = {29'h0, pll_timeout_busy, watchdog.watchdog_on, state_q == ST_RUN};
   wire logic [31:0] rd_word   = is_word ? {8'h00, word_q[idx]} :
                                 is_ctrl ? ctrl_q :
                                 is_stat ? stat_word : 32'h0;

   // only the on bit is implemented in the control register
   assign ctrl_d = ctrl_wr ? (pwdata & (32'h1 << config_word_pkg::CTRL_WD_ON)) : ctrl_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q  <= config_word_pkg::CTRL_RESET;
         prdata  <= 32'h0;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         ctrl_q  <= ctrl_d;
         prdata  <= (setup & ~pwrite) ? rd_word : 32'h0;
         pready  <= setup;
         pslverr <= setup & bad;
      end
   end

   // ************************************************************
   // assertions
   // ************************************************************
   localparam int TMO_LEN = config_word_pkg::PLL_TIMEOUT_CYC;
   wire logic run2 = (state_q == ST_RUN) & settings_valid;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   property p_unimpl_ones;
      run2 |-> (word_q[config_word_pkg::W_SECURITY][23:16] == 8'hff) &&
               (word_q[config_word_pkg::W_OSCSEL][6:3] == 4'hf);
   endproperty
   a_unimpl_ones: assert property (p_unimpl_ones) else $error("unimplemented bit reads zero"); // R1

   property p_alt_vector;
      run2 |-> security.alternate_vector_table == ~sec_w[config_word_pkg::SEC_ALT_VEC];
   endproperty
   a_alt_vector: assert property (p_alt_vector) else $error("vector table enable wrong"); // R2

   property p_cfg_level;
      run2 && cfg_lvl_code[2:1] == 2'b10 |-> security.cfg_segment_protect_level == config_word_pkg::PROT_ENHANCED;
   endproperty
   a_cfg_level: assert property (p_cfg_level) else $error("enhanced level not decoded"); // R3

   property p_boot_write_protect;
      run2 |-> security.boot_segment_protected != sec_w[config_word_pkg::SEC_BOOT_WP];
   endproperty
   a_boot_write_protect: assert property (p_boot_write_protect) else $error("boot write protect inverted"); // R4

   property p_pll_gate;
      run2 && $past(pll_lost) |-> !clock_cfg.pll_clock_out_enable;
   endproperty
   a_pll_gate: assert property (p_pll_gate) else $error("pll output not gated on lost lock"); // R13

   property p_timeout;
      tmo_start |=> pll_timeout_busy [*8] ##[1:TMO_LEN] !pll_timeout_busy;
   endproperty
   a_timeout: assert property (p_timeout) else $error("pll time-out length wrong"); // R14

   property p_wd_on;
      run2 && $past(wdt_w[config_word_pkg::WD_HW_EN]) |-> watchdog.watchdog_on;
   endproperty
   a_wd_on: assert property (p_wd_on) else $error("hardware watchdog enable ignored"); // R18

   property p_period;
      run2 |-> watchdog.run_divider_exp == {1'b0, $past(run_code)} + 6'h01;
   endproperty
   a_period: assert property (p_period) else $error("run period exponent wrong"); // R19

   property p_load_once;
      state_q == ST_RUN |=> $stable(word_q);
   endproperty
   a_load_once: assert property (p_load_once) else $error("configuration words changed after load"); // R23

   property p_apb_ready;
      setup |=> pready ##1 !pready;
   endproperty
   a_apb_ready: assert property (p_apb_ready) else $error("apb ready not one cycle after setup");

   c_timeout:  cover property (tmo_start ##[1:TMO_LEN] !pll_timeout_busy);
   c_ctrl_wr:  cover property (ctrl_wr ##1 watchdog.watchdog_on);
   c_word_rd:  cover property (setup && !pwrite && is_word ##1 pready);
   c_bad_wr:   cover property (pready && pslverr);

endmodule : config_word_decoder

`default_nettype wire

// ---- config_word_decoder_tb_top.sv ----
// self-checking bench for the configuration word decoder
`timescale 1ns/1ps
`default_nettype none
module config_word_decoder_tb_top;
   // ************************************************************
   // stimulus and dut
   // ************************************************************
   logic clk, rst_n, psel, penable, pwrite, pready, pslverr, busy, valid;
   logic [5:0][23:0] nvm_words;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic err;
   int errors, checks_done;
   config_word_pkg::live_s live;
   config_word_pkg::security_s sec;
   config_word_pkg::clocking_s clk_cfg;
   config_word_pkg::watchdog_s wd;
   config_word_decoder i_dut (.clk(clk), .rst_n(rst_n), .nvm_words(nvm_words), .live(live), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .security(sec), .clock_cfg(clk_cfg), .watchdog(wd), .pll_timeout_busy(busy),
      .settings_valid(valid));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      checks_done++;
      if (s !== e) begin
         errors++;
         $display("FAIL %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   // one apb transfer; waits for pready, no assumed latency
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      {psel, penable} <= 2'h0;
   endtask : apb
   task t_words;
      logic [5:0][23:0] exp;
      exp = {24'hff7c60, 24'hfffa7c, 24'hfffffd, 24'hff7fff, 24'hfffff0, 24'hfffcb3};
      for (int i = 0; i < 6; i++) begin
         apb(1'b0, 8'(i * 4), 32'h0);
         chk("word", rd, {8'h00, exp[i]});
      end
   endtask : t_words
   task t_decode;
      chk("sec", 32'(sec), 32'(config_word_pkg::security_s'{1'b0, config_word_pkg::PROT_STANDARD, 1'b1,
         config_word_pkg::PROT_STANDARD, 1'b0, 1'b1, config_word_pkg::PROT_HIGH, 1'b0, 13'h000f}));
      chk("clk", 32'(clk_cfg), 32'(config_word_pkg::clocking_s'{1'b1, 3'h5, 1'b0, 1'b1, 2'h2, 1'b1, 1'b1, 1'b0,
         1'b1, config_word_pkg::PRI_EXT_CLOCK}));
      chk("wd", 32'(wd), 32'(config_word_pkg::watchdog_s'{1'b0, 6'h20, 6'h01, 3'h6, 1'b1,
         config_word_pkg::WCLK_LOW_POWER_RC}));
      chk("valid", 32'(valid), 32'h1);
   endtask : t_decode
   // refused accesses leave the latched words untouched
   task t_refuse;
      apb(1'b1, 8'h00, 32'h0);
      chk("wr_err", 32'(err), 32'h1);
      apb(1'b0, 8'h00, 32'h0);
      chk("sec_kept", rd, 32'h00fffcb3);
      apb(1'b0, 8'h20, 32'h0);
      chk("bad_rd", {rd[30:0], err}, 32'h1);
   endtask : t_refuse
   task t_wdog;
      apb(1'b1, 8'h18, 32'h00008000);
      repeat (2) @(posedge clk);
      chk("wd_on", 32'(wd.watchdog_on), 32'h1);
      apb(1'b0, 8'h1c, 32'h0);
      chk("status", rd, 32'h3);
   endtask : t_wdog
   task t_pll;
      int n;
      n = 0;
      live.pll_request <= 1'b1;
      live.pll_lock <= 1'b0;
      for (int i = 0; i < 100; i++) begin
         @(posedge clk);
         if (busy === 1'b1) n++;
      end
      chk("pll_to", 32'(n), 32'(config_word_pkg::PLL_TIMEOUT_CYC));
      chk("pll_out", 32'(clk_cfg.pll_clock_out_enable), 32'h1);
   endtask : t_pll
   // second reset: lock gating and hardware watchdog enable, words then held
   task t_reload;
      rst_n <= 1'b0;
      live <= '0;
      nvm_words[4] <= 24'h001944;
      nvm_words[5] <= 24'h00fc60;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      nvm_words <= '0;
      chk("relock", 32'(clk_cfg.pll_clock_out_enable), 32'h0);
      chk("hw_wd", 32'(wd.watchdog_on), 32'h1);
      apb(1'b0, 8'h10, 32'h0);
      chk("kept", rd, 32'h00fffb7c);
   endtask : t_reload
   task wrap_up;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : wrap_up
   initial begin
      #50000;
      errors++;
      wrap_up;
   end
   initial begin
      {rst_n, psel, penable, pwrite, paddr, pwdata, live} = '0;
      // signature word keeps its reserved bit 15 at zero
      nvm_words = {24'h007c60, 24'h001844, 24'h000085, 24'h000000, 24'h001ff0, 24'h008ca3};
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      t_words;
      t_decode;
      t_refuse;
      t_wdog;
      t_pll;
      t_reload;
      wrap_up;
   end
endmodule : config_word_decoder_tb_top
`default_nettype wire
